// *** rtl/spd_pkg.sv ***
// Constants shared by the stepper port driver and its axis generator
package spd_pkg;
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          DIR_SETUP_NS   = 1000;
	localparam int          DIR_SETUP_CYC  = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          AXES           = 4;
	localparam int          CNT_W          = 16;

	// Register word addresses
	localparam logic [3:0]  ADDR_CTRL      = 4'h0;
	localparam logic [3:0]  ADDR_SPEED     = 4'h1;
	localparam logic [3:0]  ADDR_HALF_PER  = 4'h2;
	localparam logic [3:0]  ADDR_RAMP      = 4'h3;
	localparam logic [3:0]  ADDR_MOVE_X    = 4'h4;
	localparam logic [3:0]  ADDR_MOVE_Y    = 4'h5;
	localparam logic [3:0]  ADDR_MOVE_Z    = 4'h6;
	localparam logic [3:0]  ADDR_MOVE_T    = 4'h7;
	localparam logic [3:0]  ADDR_STATUS    = 4'h8;

	// Control register fields
	localparam int          CTRL_JOB_RUN   = 0;
	localparam int          CTRL_TOOL_CHG  = 1;
	localparam int          CTRL_IN_WORK   = 2;
	localparam int          CTRL_SPN_EN    = 3;
	localparam int          CTRL_SPN_INV   = 4;
	localparam int          CTRL_COOL_EN   = 5;
	localparam int          CTRL_COOL_INV  = 6;
	localparam int          CTRL_CRED_INV  = 7;
	localparam int          CTRL_TAN_MODE  = 8;
	localparam int          CTRL_W         = 9;

	// Move register fields
	localparam int          MOVE_DIR_BIT   = 16;

	// Status register fields
	localparam int          STAT_BUSY_LSB  = 0;
	localparam int          STAT_RAMP      = 4;
	localparam int          STAT_IN_LSB    = 8;
	localparam int          SW_IN_W        = 5;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST     = 9'h028;
	localparam logic [3:0]        SPEED_RST    = 4'h0;
	localparam logic [CNT_W-1:0]  HALF_PER_RST = 16'h0032;
	localparam logic [CNT_W-1:0]  RAMP_RST     = 16'h0010;

	typedef enum logic [1:0] {
		AX_IDLE  = 2'b00,
		AX_SETUP = 2'b01,
		AX_HIGH  = 2'b10,
		AX_LOW   = 2'b11
	} spd_ax_state_t;
endpackage

// *** rtl/spd_axis_gen.sv ***
// One axis: direction line and step clock pulse train with ramp flag
`timescale 1ns/10ps
`default_nettype none
module spd_axis_gen
	import spd_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic             start,
	input  wire logic             dir_in,
	input  wire logic [CNT_W-1:0] steps,
	input  wire logic [CNT_W-1:0] half_per,
	input  wire logic [CNT_W-1:0] ramp_len,
	output logic                  dir_q,
	output logic                  step_q,
	output logic                  busy,
	output logic                  in_ramp
);
	spd_ax_state_t    state_q;
	logic [CNT_W-1:0] timer_q;
	logic [CNT_W-1:0] left_q;
	logic [CNT_W-1:0] done_q;
	logic             tick;

	assign busy    = (state_q != AX_IDLE);
	assign tick    = (timer_q == '0);
	assign in_ramp = busy && ((done_q < ramp_len) || (left_q <= ramp_len));

	// Direction only moves while idle, so it is stable through the move
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			dir_q <= 1'b0;
		end else if (start && !busy && steps != '0) begin
			dir_q <= dir_in; // [R11]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= AX_IDLE;
			timer_q <= '0;
			left_q  <= '0;
			done_q  <= '0;
			step_q  <= 1'b0;
		end else begin
			if (!tick) begin
				timer_q <= timer_q - 1'b1;
			end
			case (state_q)
				AX_IDLE: begin
					if (start && steps != '0) begin
						state_q <= AX_SETUP; // [R11]
						timer_q <= CNT_W'(DIR_SETUP_CYC - 1);
						left_q  <= steps;
						done_q  <= '0;
					end
				end
				AX_SETUP: begin
					if (tick) begin
						state_q <= AX_HIGH; // [R1]
						step_q  <= 1'b1;
						timer_q <= half_per;
					end
				end
				AX_HIGH: begin
					if (tick) begin
						state_q <= AX_LOW;
						step_q  <= 1'b0;
						timer_q <= half_per;
						left_q  <= left_q - 1'b1;
						done_q  <= done_q + 1'b1;
					end
				end
				AX_LOW: begin
					if (tick) begin
						if (left_q == '0) begin
							state_q <= AX_IDLE;
						end else begin
							state_q <= AX_HIGH;
							step_q  <= 1'b1;
							timer_q <= half_per;
						end
					end
				end
				default: begin
					state_q <= AX_IDLE;
					step_q  <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** rtl/spd_port_driver.sv ***
// Parallel port signal driver for a stepper motor machine
//
// Summary of operation
// [R1] X, Y, Z each get direction and step
// [R2] Spindle high during job, off at tool change
// [R3] Coolant high while tool works in workpiece
// [R4] Current reduction high when no motor steps
// [R5] Three-axis: boost high during ramp movement
// [R6] Three-axis: one spare output held high
// [R7] Tangential: fourth axis replaces high and boost
// [R8] Machine presents switches and ready on inputs
// [R9] Second port carries 4-bit spindle speed level
// [R10] Speed level plain binary, low four lines
// [R11] Direction settles before first step, holds
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module spd_port_driver
	import spd_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic [4:0]  sw_in,
	output logic      [7:0]  port_data,
	output logic             port_spindle,
	output logic             port_coolant,
	output logic             port_boost,
	output logic             port_cur_red,
	output logic      [7:0]  speed_data
);
	logic [CTRL_W-1:0]  ctrl_q;
	logic [3:0]         speed_q;
	logic [CNT_W-1:0]   half_per_q;
	logic [CNT_W-1:0]   ramp_q;
	logic [SW_IN_W-1:0] sw_q;
	logic [AXES-1:0]    start;
	logic [AXES-1:0]    dir;
	logic [AXES-1:0]    step;
	logic [AXES-1:0]    busy;
	logic [AXES-1:0]    ramp;
	logic               tan_mode;
	logic               any_busy;
	logic               any_ramp;
	logic               spindle_d;
	logic               coolant_d;
	logic               cur_red_d;
	logic               boost_d;
	logic [7:0]         data_d;

	// Output gate: disabled line stays low whatever the polarity
	function automatic logic apply_pol(input logic en, input logic inv, input logic raw);
		apply_pol = en ? (raw ^ inv) : 1'b0;
	endfunction

	assign tan_mode = ctrl_q[CTRL_TAN_MODE];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RST;
		end else if (reg_wr && reg_addr == ADDR_CTRL) begin
			ctrl_q <= reg_wdata[CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			speed_q <= SPEED_RST;
		end else if (reg_wr && reg_addr == ADDR_SPEED) begin
			speed_q <= reg_wdata[3:0]; // [R9]
		end
	end

	// Half-period changes mid-move take effect at the next half period; ramp length changes act on the next clock
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			half_per_q <= HALF_PER_RST;
			ramp_q     <= RAMP_RST;
		end else if (reg_wr && reg_addr == ADDR_HALF_PER) begin
			half_per_q <= reg_wdata[CNT_W-1:0];
		end else if (reg_wr && reg_addr == ADDR_RAMP) begin
			ramp_q <= reg_wdata[CNT_W-1:0];
		end
	end

	// Switch lines are taken as synchronous; one register for a clean read
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sw_q <= '0;
		end else begin
			sw_q <= sw_in; // [R8]
		end
	end

	// Move writes to a busy axis are dropped by the generator
	always_comb begin
		for (int i = 0; i < AXES; i++) begin
			start[i] = reg_wr && (reg_addr == ADDR_MOVE_X + 4'(i));
		end
		start[AXES-1] = start[AXES-1] && tan_mode; // [R7]
	end

	for (genvar g = 0; g < AXES; g++) begin : g_axis
		spd_axis_gen u_axis (
			.clk_sys  (clk_sys),
			.sys_rst  (sys_rst),
			.start    (start[g]),
			.dir_in   (reg_wdata[MOVE_DIR_BIT]),
			.steps    (reg_wdata[CNT_W-1:0]),
			.half_per (half_per_q),
			.ramp_len (ramp_q),
			.dir_q    (dir[g]),
			.step_q   (step[g]),
			.busy     (busy[g]),
			.in_ramp  (ramp[g])
		);
	end

	assign any_busy = |busy;
	assign any_ramp = |ramp[2:0];

	always_comb begin
		data_d = 8'h00;
		for (int i = 0; i < 3; i++) begin
			data_d[2*i]   = dir[i];  // [R1]
			data_d[2*i+1] = step[i]; // [R1]
		end
		if (tan_mode) begin
			data_d[6] = dir[3];  // [R7]
			data_d[7] = step[3]; // [R7]
		end else begin
			data_d[6] = 1'b1; // [R6]
			data_d[7] = 1'b0;
		end
	end

	assign spindle_d = apply_pol(ctrl_q[CTRL_SPN_EN], ctrl_q[CTRL_SPN_INV],
		ctrl_q[CTRL_JOB_RUN] && !ctrl_q[CTRL_TOOL_CHG]); // [R2]
	// Software drops the in-work flag before retracting the tool
	assign coolant_d = apply_pol(ctrl_q[CTRL_COOL_EN], ctrl_q[CTRL_COOL_INV],
		ctrl_q[CTRL_JOB_RUN] && ctrl_q[CTRL_IN_WORK]); // [R3]
	assign cur_red_d = !any_busy ^ ctrl_q[CTRL_CRED_INV]; // [R4]
	assign boost_d   = !tan_mode && any_ramp; // [R5]

	// All port lines registered so they change together and glitch free
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			port_data    <= 8'h00;
			port_spindle <= 1'b0;
			port_coolant <= 1'b0;
			port_boost   <= 1'b0;
			port_cur_red <= 1'b1;
		end else begin
			port_data    <= data_d;
			port_spindle <= spindle_d;
			port_coolant <= coolant_d;
			port_boost   <= boost_d;
			port_cur_red <= cur_red_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			speed_data <= 8'h00;
		end else begin
			speed_data <= {4'h0, speed_q}; // [R10]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_CTRL:     reg_rdata <= 32'(ctrl_q);
				ADDR_SPEED:    reg_rdata <= 32'(speed_q);
				ADDR_HALF_PER: reg_rdata <= 32'(half_per_q);
				ADDR_RAMP:     reg_rdata <= 32'(ramp_q);
				ADDR_STATUS: begin
					reg_rdata <= 32'({sw_q, 3'b000, any_ramp, busy}); // [R8]
				end
				default:       reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// *** tb/spd_chk.sv ***
// Checker on the stepper port driver outputs
`timescale 1ns/10ps
`default_nettype none
module spd_chk
	import spd_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic [3:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic [7:0]  port_data,
	input wire logic        port_spindle,
	input wire logic        port_coolant,
	input wire logic        port_boost,
	input wire logic        port_cur_red,
	input wire logic [7:0]  speed_data
);
	logic [CTRL_W-1:0] c_q;
	logic [CTRL_W-1:0] p_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			c_q <= CTRL_RST;
		end else if (reg_wr && reg_addr == ADDR_CTRL) begin
			c_q <= reg_wdata[CTRL_W-1:0];
		end
	end
	// Delayed copy matches the output register lag
	always_ff @(posedge clk_sys) begin
		p_q <= c_q;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_spd_wr;
		reg_wr && reg_addr == ADDR_SPEED;
	endsequence
	chk_x_dir_hold: assert property (port_data[1] |-> $stable(port_data[0]))
		else $error("x dir moved in step");
	chk_spindle_out: assert property (port_spindle == (p_q[CTRL_SPN_EN] &
		((p_q[CTRL_JOB_RUN] & !p_q[CTRL_TOOL_CHG]) ^ p_q[CTRL_SPN_INV])))
		else $error("spindle level");
	chk_coolant_out: assert property (port_coolant == (p_q[CTRL_COOL_EN] &
		((p_q[CTRL_JOB_RUN] & p_q[CTRL_IN_WORK]) ^ p_q[CTRL_COOL_INV])))
		else $error("coolant level");
	chk_cred_step: assert property (|{port_data[1], port_data[3], port_data[5]}
		|-> port_cur_red == p_q[CTRL_CRED_INV]) else $error("cur_red in step");
	chk_boost_busy: assert property (port_boost |-> port_cur_red == p_q[CTRL_CRED_INV])
		else $error("boost while idle");
	chk_spare_high: assert property (!$past(sys_rst) && !p_q[CTRL_TAN_MODE]
		|-> port_data[7:6] == 2'h1) else $error("spare line");
	chk_tan_boost: assert property (p_q[CTRL_TAN_MODE] |-> !port_boost)
		else $error("boost in tan mode");
	chk_speed_code: assert property (s_spd_wr |-> ##2
		speed_data == {4'h0, $past(reg_wdata[3:0], 2)}) else $error("speed code");
endmodule
bind spd_port_driver spd_chk u_spd_chk (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
	.reg_wr, .port_data, .port_spindle, .port_coolant, .port_boost, .port_cur_red,
	.speed_data);
`default_nettype wire

// *** tb/spd_machine.sv ***
// Machine model: X position and switch lines
`timescale 1ns/10ps
`default_nettype none
module spd_machine (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [7:0] port_data,
	output logic      [4:0] sw_in
);
	int   x_q;
	logic s_q;
	always_ff @(posedge clk_sys) begin
		s_q <= port_data[1];
		if (sys_rst) begin
			x_q <= 0;
		end else if (port_data[1] && !s_q) begin
			x_q <= x_q + (port_data[0] ? 1 : -1);
		end
	end
	// X limit at three steps, ready always high
	assign sw_in = {1'b1, 3'h0, x_q >= 3};
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench for the stepper port driver
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import spd_pkg::*;
;
	logic        clk_sys = 0;
	logic        sys_rst = 1;
	logic        reg_wr = 0;
	logic        reg_rd = 0;
	logic [3:0]  reg_addr = 0;
	logic [31:0] reg_wdata = 0;
	logic [31:0] reg_rdata, d;
	logic [7:0]  port_data, speed_data;
	logic        port_spindle, port_coolant, port_boost, port_cur_red, bo;
	logic [4:0]  sw_in;
	int          err_count = 0;
	int          n_checks = 0;
	int          n;
	wire [31:0]  pk = {8'h0, port_data, speed_data, 4'h0, port_boost, port_cur_red,
		port_coolant, port_spindle};
	logic [8:0]  cv [5] = '{9'h029, 9'h02D, 9'h02B, 9'h07C, 9'h005};
	logic [1:0]  ev [5] = '{2'h1, 2'h3, 2'h0, 2'h3, 2'h0};
	always #50 clk_sys = ~clk_sys;
	spd_port_driver u_spd_port_driver (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .sw_in, .port_data, .port_spindle, .port_coolant,
		.port_boost, .port_cur_red, .speed_data);
	spd_machine u_spd_machine (.clk_sys, .sys_rst, .port_data, .sw_in);
	task tk(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
			err_count++;
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Counts step rises until the current reduction line returns
	task mv(input logic [3:0] a, input int sb, input logic [16:0] w);
		int i;
		logic pv;
		n = 0;
		bo = 0;
		pv = 0;
		wr(a, {15'h0, w});
		tk(3);
		for (i = 0; i < 300 && port_cur_red !== 1'b1; i++) begin
			if (port_data[sb] && !pv) n++;
			if (port_data[sb]) chk(port_data[sb-1], w[16]);
			bo |= port_boost;
			pv = port_data[sb];
			tk(1);
		end
		if (i == 300) begin
			$display("[FAIL] %0t wait limit got %h exp %h", $time, i, 300);
			err_count++;
			final_report;
		end
	endtask
	task t_reset;
		rd(ADDR_CTRL);
		chk(d, 32'h28);
		rd(ADDR_SPEED);
		chk(d, 32'h0);
		rd(ADDR_HALF_PER);
		chk(d, 32'h32);
		rd(ADDR_RAMP);
		chk(d, 32'h10);
		rd(4'hF);
		chk(d, 32'h0);
		chk(pk, 32'h0040_0004);
		$display("t_reset done");
	endtask
	task t_speed;
		for (int i = 1; i < 16; i++) begin
			wr(ADDR_SPEED, i);
			tk(2);
			chk(speed_data, i);
		end
		$display("t_speed done");
	endtask
	task t_spin;
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_CTRL, {23'h0, cv[i]});
			tk(2);
			chk({port_coolant, port_spindle}, ev[i]);
		end
		wr(ADDR_CTRL, 32'hA8);
		tk(2);
		chk(port_cur_red, 0);
		wr(ADDR_CTRL, 32'h28);
		$display("t_spin done");
	endtask
	task t_move;
		wr(ADDR_HALF_PER, 32'h2);
		tk(2);
		chk(port_cur_red, 1);
		mv(ADDR_MOVE_X, 1, 17'h10003);
		chk(n, 3);
		chk(bo, 1);
		rd(ADDR_STATUS);
		chk(d[12:0], 13'h1100);
		mv(ADDR_MOVE_Z, 5, 17'h00002);
		chk(n, 2);
		mv(ADDR_MOVE_Y, 3, 17'h00001);
		chk(n, 1);
		// Busy and ramp flags seen while a Y move runs
		wr(ADDR_MOVE_Y, 32'h0001_0001);
		rd(ADDR_STATUS);
		chk(d[4:0], 5'h12);
		tk(30);
		chk(port_cur_red, 1);
		// Fourth axis refused outside tangential mode
		wr(ADDR_MOVE_T, 32'h0001_0002);
		tk(3);
		chk(port_cur_red, 1);
		$display("t_move done");
	endtask
	task t_tan;
		wr(ADDR_CTRL, 32'h128);
		tk(2);
		chk(port_data[7:6], 0);
		mv(ADDR_MOVE_T, 7, 17'h10002);
		chk({n[3:0], bo}, 5'h4);
		wr(ADDR_CTRL, 32'h28);
		tk(2);
		chk(port_data[7:6], 1);
		$display("t_tan done");
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		chk(pk, 32'h4);
		sys_rst <= 0;
		t_reset;
		t_speed;
		t_spin;
		t_move;
		t_tan;
		final_report;
	end
endmodule
`default_nettype wire
